// [rtl/srs_sequencer.v]
// srs_sequencer.v: reset sequencer that drives the shared reset line, master
// reset, processor reset state and module pin defaults
// assumes: one 10 MHz clock; reset pin and requests are asynchronous inputs;
// the bus reports bus_cycle_end; nrst is the power-on reset
`default_nettype none
`include "srs_defines.vh"
module srs_sequencer (
  input  wire                     clk,
  input  wire                     nrst,
  input  wire                     reset_pin_in,
  output reg                      reset_pin_out,
  output reg                      reset_pin_oe,
  input  wire                     pll_locked,
  input  wire                     wdog_req,
  input  wire                     halt_req,
  input  wire                     bus_cycle_end,
  input  wire                     breakpoint_input_n,
  input  wire                     boot_from_ram,
  input  wire                     vector_done,
  output reg                      master_reset_internal,
  output reg                      module_reset,
  output reg                      cpu_run,
  output reg                      trace_bit_low,
  output reg                      trace_bit_high,
  output reg                      supervisor_bit,
  output reg  [2:0]               ipl_mask,
  output reg  [31:0]              vector_base,
  output reg                      background_debug_flag,
  output reg                      load_ssp,
  output reg                      load_pc,
  output reg                      fetch_first,
  output reg                      boot_chip_select,
  output reg                      first_bus_ok,
  output reg                      sim_pins_oe,
  output reg  [`SRS_DEF_W-1:0]    port_dir,
  output reg  [`SRS_DEF_W-1:0]    alt_func_en,
  output reg  [`SRS_NSRC-1:0]     reset_cause_register
);
  // one-hot sequencer states
  localparam [6:0] ST_POR   = 7'h01;
  localparam [6:0] ST_WAIT  = 7'h02;
  localparam [6:0] ST_HOLD  = 7'h04;
  localparam [6:0] ST_DRIVE = 7'h08;
  localparam [6:0] ST_FLOAT = 7'h10;
  localparam [6:0] ST_VEC   = 7'h20;
  localparam [6:0] ST_RUN   = 7'h40;

  // vector fetch steps, one-hot
  localparam [3:0] VF_BREAKPOINT_INPUT = 4'h1;
  localparam [3:0] VF_SSP  = 4'h2;
  localparam [3:0] VF_PC   = 4'h4;
  localparam [3:0] VF_GO   = 4'h8;

  wire [4:0] sync_q;
  wire       pin_s;
  wire       wdog_s;
  wire       halt_s;
  wire       lock_s;
  wire       breakpoint_input_n_s;

  reg  [6:0]               state_reg;
  reg  [6:0]               state_next;
  reg  [3:0]               vf_reg;
  reg  [`SRS_CNT_W-1:0]    cnt_reg;
  reg  [`SRS_CNT_W-1:0]    cnt_next;
  reg  [`SRS_CNT_W-1:0]    bus_cnt_reg;
  reg  [2:0]               hold_cnt_reg;
  reg  [`SRS_NSRC-1:0]     cause_reg;
  reg                      drive_next;
  reg                      oe_next;
  wire                     int_req;
  wire                     release_evt;

  // pin, breakpoint, watchdog, halt and lock come from outside this clock domain
  srs_sync #(
    .W (5)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({breakpoint_input_n, pll_locked, halt_req, wdog_req, reset_pin_in}),
    .q    (sync_q)
  );

  assign pin_s   = sync_q[0];
  assign wdog_s  = sync_q[1];
  assign halt_s  = sync_q[2];
  assign lock_s  = sync_q[3];
  assign breakpoint_input_n_s = sync_q[4];
  assign int_req = wdog_s | halt_s;
  assign release_evt = state_reg[4] && (cnt_reg == `SRS_FLOAT_CYC) && pin_s;

  // sequencer next-state; external pin low seen while we float it is a request
  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 10'h001;
    drive_next = 1'b1;
    oe_next    = 1'b1;
    case (state_reg)
      ST_POR:
      begin
        cnt_next = 10'h000;
        if (lock_s)
          state_next = ST_DRIVE;
      end
      ST_WAIT:
      begin
        // external request waits for bus cycle end so writes finish
        drive_next = 1'b0;
        oe_next    = 1'b0;
        cnt_next   = 10'h000;
        if (bus_cycle_end)
          state_next = ST_HOLD;
      end
      ST_HOLD:
      begin
        // leave the line undriven until the outside party lets go, then drive and count 512
        oe_next  = 1'b0;
        cnt_next = 10'h000;
        if (pin_s)
          state_next = ST_DRIVE;
      end
      ST_DRIVE:
      begin
        if (cnt_reg >= `SRS_DRIVE_CYC - 10'h001 && !int_req)
        begin
          state_next = ST_FLOAT;
          cnt_next   = 10'h001;
          oe_next    = 1'b0;
        end
        else if (cnt_reg >= `SRS_DRIVE_CYC - 10'h001)
          cnt_next = cnt_reg; // hold count while request stays
      end
      ST_FLOAT:
      begin
        oe_next = 1'b0;
        if (cnt_reg == `SRS_FLOAT_CYC)
        begin
          cnt_next = 10'h000;
          if (pin_s)
          begin
            state_next = ST_VEC;
            drive_next = 1'b0;
          end
          else
          begin
            state_next = ST_DRIVE;
            oe_next    = 1'b1;
          end
        end
      end
      ST_VEC:
      begin
        drive_next = 1'b0;
        oe_next    = 1'b0;
        cnt_next   = 10'h000;
        if (vf_reg[3])
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        drive_next = 1'b0;
        oe_next    = 1'b0;
        cnt_next   = 10'h000;
        if (int_req)
          state_next = ST_DRIVE; // internal sources act at once
        else if (!pin_s)
          state_next = ST_WAIT;
      end
      default:
      begin
        state_next = ST_POR;
        cnt_next   = 10'h000;
      end
    endcase
    if (int_req && (state_reg[1] || state_reg[2]))
    begin
      state_next = ST_DRIVE;
      cnt_next   = 10'h000;
      oe_next    = 1'b1;
    end
  end

  // sequencer registers and pin drive; the pin only ever pulls low
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg     <= ST_POR;
      cnt_reg       <= 10'h000;
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= 1'b1;
    end
    else
    begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= (oe_next & drive_next) | state_next[3]; // full 512 from any entry
    end
  end

  // cause bits collect during reset and publish on pin release
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cause_reg            <= 4'h1 << `SRS_SRC_POR;
      reset_cause_register <= 4'h0;
    end
    else
    begin
      if (state_reg[1])
        cause_reg[`SRS_SRC_EXT] <= 1'b1;
      if (wdog_s)
        cause_reg[`SRS_SRC_WDOG] <= 1'b1;
      if (halt_s)
        cause_reg[`SRS_SRC_HALT] <= 1'b1;
      if (release_evt)
      begin
        reset_cause_register <= cause_reg;
        cause_reg            <= 4'h0;
      end
    end
  end

  // master reset and module reset, modules wait four held cycles
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      master_reset_internal <= 1'b1;
      module_reset          <= 1'b0;
      hold_cnt_reg          <= 3'h0;
    end
    else
    begin
      // an outside request stays off the core until the bus cycle has ended
      master_reset_internal <= ~(state_reg[1] | state_reg[5] | state_reg[6])
                               | state_next[3];
      if (!master_reset_internal)
        hold_cnt_reg <= 3'h0;
      else if (hold_cnt_reg != `SRS_MOD_HOLD_CYC)
        hold_cnt_reg <= hold_cnt_reg + 3'h1;
      module_reset <= master_reset_internal &&
                      (hold_cnt_reg == `SRS_MOD_HOLD_CYC);
    end
  end

  // processor state while master reset; vector fetch after release
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cpu_run               <= 1'b0;
      trace_bit_low         <= 1'b0;
      trace_bit_high        <= 1'b0;
      supervisor_bit        <= 1'b1;
      ipl_mask              <= `SRS_IPL_RESET;
      vector_base           <= `SRS_VBR_RESET;
      background_debug_flag <= 1'b0;
      load_ssp              <= 1'b0;
      load_pc               <= 1'b0;
      fetch_first           <= 1'b0;
      vf_reg                <= VF_BREAKPOINT_INPUT;
    end
    else if (master_reset_internal)
    begin
      cpu_run        <= 1'b0;
      trace_bit_low  <= 1'b0;
      trace_bit_high <= 1'b0;
      supervisor_bit <= 1'b1;
      ipl_mask       <= `SRS_IPL_RESET;
      vector_base    <= `SRS_VBR_RESET;
      load_ssp       <= 1'b0;
      load_pc        <= 1'b0;
      fetch_first    <= 1'b0;
      vf_reg         <= VF_BREAKPOINT_INPUT;
    end
    else
    begin
      load_ssp    <= 1'b0;
      load_pc     <= 1'b0;
      fetch_first <= 1'b0;
      case (vf_reg)
        VF_BREAKPOINT_INPUT:
        begin
          background_debug_flag <= ~breakpoint_input_n_s;
          load_ssp              <= 1'b1;
          vf_reg                <= VF_SSP;
        end
        VF_SSP:
          if (vector_done)
          begin
            load_pc <= 1'b1;
            vf_reg  <= VF_PC;
          end
        VF_PC:
          if (vector_done)
          begin
            fetch_first <= 1'b1;
            cpu_run     <= 1'b1;
            vf_reg      <= VF_GO;
          end
        VF_GO:
          vf_reg <= VF_GO;
        default:
          vf_reg <= VF_BREAKPOINT_INPUT;
      endcase
    end
  end

  // bus start delay, boot select and pin defaults
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_cnt_reg      <= 10'h000;
      first_bus_ok     <= 1'b0;
      boot_chip_select <= 1'b1;
      sim_pins_oe      <= 1'b0;
      port_dir         <= 16'h0000;
      alt_func_en      <= 16'h0000;
    end
    else
    begin
      if (master_reset_internal)
        bus_cnt_reg <= 10'h000;
      else if (bus_cnt_reg != `SRS_FIRST_BUS_CYC)
        bus_cnt_reg <= bus_cnt_reg + 10'h001;
      first_bus_ok <= !master_reset_internal &&
                      (bus_cnt_reg == `SRS_FIRST_BUS_CYC);
      // boot ROM selected only when vectors are not in RAM, active low
      boot_chip_select <= master_reset_internal | boot_from_ram;
      sim_pins_oe      <= ~master_reset_internal;
      if (master_reset_internal)
      begin
        port_dir    <= 16'h0000;
        alt_func_en <= 16'h0000;
      end
    end
  end
endmodule // srs_sequencer
`default_nettype wire

// [rtl/srs_defines.vh]
// srs_defines.vh: constants for the system reset sequencer
// assumes: included by bare name from rtl files, 10 MHz system clock
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH
`define SRS_CLK_NS        100
`define SRS_DRIVE_CYC     10'h200
`define SRS_FLOAT_CYC     10'h00A
`define SRS_FIRST_BUS_CYC 10'h00A
`define SRS_MOD_HOLD_CYC  3'h4
`define SRS_CNT_W         10
`define SRS_NSRC          4
`define SRS_SRC_EXT       0
`define SRS_SRC_POR       1
`define SRS_SRC_WDOG      2
`define SRS_SRC_HALT      3
`define SRS_IPL_RESET     3'h7
`define SRS_VBR_RESET     32'h00000000
`define SRS_DEF_W         16
`endif

// [rtl/srs_sync.v]
// srs_sync.v: two-flop synchroniser for a bundle of level inputs
// assumes: inputs are asynchronous to clk, each bit independent
`default_nettype none
module srs_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // srs_sync
`default_nettype wire

// [bench/srs_sequencer_assertions.sv]
// srs_sequencer_assertions.sv: port checker for srs_sequencer
// assumes: one clock, nrst async active low, bound at the foot
`default_nettype none
module srs_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        reset_pin_oe,
  input wire logic        master_reset_internal,
  input wire logic        module_reset,
  input wire logic        cpu_run,
  input wire logic        trace_bit_low,
  input wire logic        trace_bit_high,
  input wire logic        supervisor_bit,
  input wire logic [2:0]  ipl_mask,
  input wire logic [31:0] vector_base,
  input wire logic        load_ssp,
  input wire logic        fetch_first,
  input wire logic        sim_pins_oe,
  input wire logic [15:0] port_dir,
  input wire logic [15:0] alt_func_en,
  input wire logic [3:0]  reset_cause_register
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] drv_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // length of the current pull on the line, zero while floating
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      drv_cnt <= 11'h000;
    else
      drv_cnt <= reset_pin_oe ? drv_cnt + 11'h001 : 11'h000;
  end
  a_core_state: assert property (master_reset_internal && $past(master_reset_internal)
    |-> !cpu_run && !trace_bit_low && !trace_bit_high && supervisor_bit && ipl_mask == 3'h7)
    else $error("core state");
  a_vbr_zero: assert property (master_reset_internal && $past(master_reset_internal)
    |-> vector_base == 32'h00000000) else $error("vector base");
  a_pin_defaults: assert property (master_reset_internal && $past(master_reset_internal)
    |-> port_dir == 16'h0000 && alt_func_en == 16'h0000 && !sim_pins_oe) else $error("pins");
  a_module_hold: assert property ($rose(module_reset) |-> $past(master_reset_internal, 4)
    && $past(master_reset_internal, 3) && $past(master_reset_internal, 2)) else $error("module");
  a_drive_min: assert property ($fell(reset_pin_oe) |-> drv_cnt >= 11'h200)
    else $error("short drive");
  a_float_span: assert property ($fell(reset_pin_oe) |-> !reset_pin_oe [*8] ##1
    !reset_pin_oe [*2]) else $error("float span");
  a_cause_release: assert property ($changed(reset_cause_register)
    |=> $fell(master_reset_internal)) else $error("cause update");
  a_ssp_first: assert property ($fell(master_reset_internal) |-> ##[0:8] load_ssp)
    else $error("no stack load");
  c_release: cover property ($fell(master_reset_internal));
  c_modules: cover property ($rose(module_reset));
  c_fetch: cover property ($rose(fetch_first));
endmodule // srs_chk
bind srs_sequencer srs_chk u_chk (.clk, .nrst, .reset_pin_oe, .master_reset_internal,
  .module_reset, .cpu_run, .trace_bit_low, .trace_bit_high, .supervisor_bit, .ipl_mask,
  .vector_base, .load_ssp, .fetch_first, .sim_pins_oe, .port_dir, .alt_func_en,
  .reset_cause_register);
`default_nettype wire

// [bench/srs_ext_dev.sv]
// srs_ext_dev.sv: outside device sharing the reset line
// assumes: line has a pull-up; the bench raises hold_req for a reset
`default_nettype none
module srs_ext_dev (
  input  wire logic clk,
  input  wire logic hold_req,
  input  wire logic dut_oe,
  output wire logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] span = 4'h0;
  // a short request is stretched so the device cannot miss it
  always @(posedge clk)
  begin
    span <= hold_req ? 4'h8 : span - {3'h0, |span};
  end
  // wired low from either party, pull-up otherwise
  assign line = !(dut_oe || hold_req || |span);
endmodule // srs_ext_dev
`default_nettype wire

// [bench/srs_sequencer_tb.sv]
// srs_sequencer_tb.sv: self-checking bench for srs_sequencer
// assumes: checker bound in its own file, outside device model
`default_nettype none
module srs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // pins start at safe idle levels before power-up completes
  logic clk = 1'b0, nrst = 1'b0, pll_locked = 1'b0, wdog_req = 1'b0, halt_req = 1'b0;
  logic bus_cycle_end = 1'b0, breakpoint_input_n = 1'b1, boot_from_ram = 1'b0;
  logic vector_done = 1'b0, hold_req = 1'b0, bce_off = 1'b0, reset_pin_in;
  logic reset_pin_oe, master_reset_internal, load_ssp, load_pc, fetch_first;
  logic reset_pin_out, first_bus_ok;
  logic supervisor_bit, background_debug_flag, boot_chip_select, sim_pins_oe;
  logic [2:0]  ipl_mask;
  logic [31:0] vector_base;
  logic [15:0] port_dir, alt_func_en;
  logic [3:0]  reset_cause_register;
  logic [31:0] seed = 32'h00000047;
  int error_cnt = 0;
  int tests_run = 0;
  int dlen = 0;
  int dq[$];
  always #50 clk = ~clk;
  srs_ext_dev ext (.clk, .hold_req, .dut_oe(reset_pin_oe), .line(reset_pin_in));
  srs_sequencer dut (.clk, .nrst, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .pll_locked,
    .wdog_req, .halt_req, .bus_cycle_end, .breakpoint_input_n, .boot_from_ram, .vector_done,
    .master_reset_internal, .module_reset(), .cpu_run(), .trace_bit_low(), .trace_bit_high(),
    .supervisor_bit, .ipl_mask, .vector_base, .background_debug_flag, .load_ssp, .load_pc,
    .fetch_first, .boot_chip_select, .first_bus_ok, .sim_pins_oe, .port_dir, .alt_func_en,
    .reset_cause_register);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // random bus cycle ends; queue up each span the device pulls the line
  always @(negedge clk)
  begin
    bus_cycle_end <= !bce_off && (rnd() % 5 == 0);
    if (reset_pin_oe)
      dlen <= dlen + 1;
    else if (dlen > 0)
    begin
      dq.push_back(dlen);
      dlen <= 0;
    end
  end
  // wait for release, compare cause and drive spans, then walk the vectors
  task automatic finish_reset(input logic [3:0] cause, input int spans, input int min_len);
    logic [31:0] r;
    int          i;
    r = rnd();
    breakpoint_input_n = r[0];
    boot_from_ram = r[1];
    for (i = 0; i < 3000 && master_reset_internal !== 1'b0; i++) @(negedge clk);
    check(reset_cause_register, cause);
    check(dq.size(), spans);
    foreach (dq[k]) check(dq[k] >= min_len, 1'b1);
    dq.delete();
    for (i = 0; i < 10 && load_ssp !== 1'b1; i++) @(negedge clk);
    check(load_ssp, 1'b1);
    check(first_bus_ok, 1'b0);
    check(background_debug_flag, !r[0]);
    check(boot_chip_select, r[1]);
    for (int j = 0; j < 2; j++)
    begin
      vector_done = 1'b1;
      @(negedge clk);
      vector_done = 1'b0;
      for (i = 0; i < 8 && (j ? fetch_first : load_pc) !== 1'b1; i++) @(negedge clk);
      check(j ? fetch_first : load_pc, 1'b1);
    end
    repeat (20) @(negedge clk);
    check(first_bus_ok, 1'b1);
  endtask
  initial
  begin
    int n;
    int i;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (30) @(negedge clk);
    pll_locked = 1'b1;
    repeat (200) @(negedge clk);
    check({reset_pin_oe, reset_pin_out, master_reset_internal}, 3'b101);
    check({supervisor_bit, ipl_mask}, 4'hF);
    check(vector_base, 32'h00000000);
    check({port_dir, alt_func_en}, 32'h00000000);
    check(sim_pins_oe, 1'b0);
    finish_reset(4'h2, 1, 552);
    // watchdog then halt request, held for a random span
    for (int k = 0; k < 2; k++)
    begin
      n = 100 + int'(rnd() % 800);
      wdog_req = (k == 0);
      halt_req = (k == 1);
      repeat (n) @(negedge clk);
      check(master_reset_internal, 1'b1);
      wdog_req = 1'b0;
      halt_req = 1'b0;
      finish_reset(4'h4 << k, 1, n > 516 ? n - 4 : 512);
    end
    // outside reset must wait for the bus cycle to end
    bce_off = 1'b1;
    hold_req = 1'b1;
    repeat (20) @(negedge clk);
    check({reset_pin_oe, master_reset_internal}, 2'b00);
    bce_off = 1'b0;
    // short hold, then one that outlasts the first drive and float
    for (int k = 0; k < 2; k++)
    begin
      hold_req = 1'b1;
      for (i = 0; i < 100 && master_reset_internal !== 1'b1; i++) @(negedge clk);
      check({reset_pin_oe, master_reset_internal}, 2'b01);
      repeat (20) @(negedge clk);
      hold_req = 1'b0;
      if (k)
      begin
        // pull the line again once the device drives, so its first float reads low
        for (i = 0; i < 100 && reset_pin_oe !== 1'b1; i++) @(negedge clk);
        hold_req = 1'b1;
        repeat (540) @(negedge clk);
        hold_req = 1'b0;
      end
      finish_reset(4'h1, k + 1, 512);
    end
    tally_and_finish();
  end
  // the scenarios need under 6000 cycles, so 20000 means a hang
  initial
  begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // srs_sequencer_tb
`default_nettype wire
